// [emb_bus_if.sv]
/*
  external program and data memory bus of a 4-clock-per-instruction core,
  with an avalon-mm register slave. assumes the pin inputs are synchronous
  to core_clk and an address latch outside captures the low address byte.
*/
// Operation
// R1 - latch strobe pulses continuously at half the core clock rate
// R2 - each external data move omits a latch strobe pulse from the train
// R3 - latch and program-store pins are sampled as mode straps at reset
// R4 - unused program-store pin outputs osc clock, modulator clock, high, low
// R5 - fetch select low starts external code fetch at address 0000
// R6 - high address port carries address bits 8 to 15 in bit order
// R7 - 16-bit address; low byte and data share the low port
// R8 - one instruction cycle is four core clocks
// R9 - moves change pointers and data exactly as the standard core would
// R10 - timer counts every 12 clocks, or every 4 when fast is set
// R11 - stretch code 0 to 7 gives data moves of 2 to 9 cycles
// R12 - read or write strobe lasts 2,4,8,...,28 clocks per stretch code
// R13 - low and high ports are either the memory bus or plain gpio
// R14 - two selectable data pointers address external data moves
// R15 - active-low read and write strobes during external data moves
// R16 - outside latch takes low address on latch strobe falling edge
module emb_bus_if #(
  parameter int MOD_DIV = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] low_addr_data_port_in,
  output logic [7:0] low_addr_data_port_out,
  output logic [7:0] low_addr_data_port_oe,
  input wire logic [7:0] high_addr_port_in,
  output logic [7:0] high_addr_port_out,
  output logic [7:0] high_addr_port_oe,
  input wire logic addr_latch_strobe_in,
  output logic addr_latch_strobe_out,
  output logic addr_latch_strobe_oe,
  input wire logic program_store_strobe_n_in,
  output logic program_store_strobe_n_out,
  output logic program_store_strobe_n_oe,
  input wire logic external_fetch_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] strap_mode
);

  emb_pkg::emb_state_e st;
  logic strap_done, normal, half, launch, move_go, move_end, busy;
  logic osc_tog, mod_tog, mod_tick, tmr_tick, fetch_en;
  logic move_pend, move_dir, move_done;
  logic [1:0] mc_phase;
  logic [3:0] clock_and_stretch_control;
  logic [4:0] ctrl;
  logic [4:0] cnt, strobe_w, rest_len;
  logic [15:0] dptr0, dptr1, data_pointer_reg_act, pc, gpio_out, gpio_oe, timer;
  logic [7:0] xdata, fetch_byte, idx;
  logic [31:0] rd_mux;
  logic wr_ack, cmd_ok;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign idx = avs_address[9:2];
  assign wr_ack = avs_write && !avs_waitrequest;
  assign normal = strap_done && (strap_mode == emb_pkg::MODE_NORMAL);
  assign fetch_en = normal && ctrl[emb_pkg::CT_EXT_EN_BIT] &&
                    !external_fetch_select_n; // [R5]
  assign data_pointer_reg_act = ctrl[emb_pkg::CT_DATA_POINTER_REG_SEL_BIT] ? dptr1 : dptr0; // [R14]
  assign busy = move_pend || (st == emb_pkg::ST_ADDR) ||
                (st == emb_pkg::ST_STROBE) || (st == emb_pkg::ST_RECOVER);
  assign cmd_ok = wr_ack && (idx == emb_pkg::IDX_CMD) && !busy && normal &&
                  ctrl[emb_pkg::CT_EXT_EN_BIT] &&
                  (avs_writedata[emb_pkg::CMD_READ_BIT] ||
                   avs_writedata[emb_pkg::CMD_WRITE_BIT]);

  // strobe width and tail so a move lasts (code + 2) instruction cycles
  always_comb begin
    if (clock_and_stretch_control[2:0] == 3'h0) begin
      strobe_w = emb_pkg::STROBE_MIN; // [R12]
      rest_len = emb_pkg::REST_SHORT; // [R11]
    end else begin
      strobe_w = {clock_and_stretch_control[2:0], 2'b00}; // [R12]
      rest_len = emb_pkg::REST_LONG; // [R11]
    end
  end

  // a new bus slot may only begin on the first clock of a strobe period
  always_comb begin
    launch = half && ((st == emb_pkg::ST_IDLE) ||
                      (st == emb_pkg::ST_FETCH_B) ||
                      (st == emb_pkg::ST_RECOVER && cnt == 5'h00));
  end
  assign move_go = normal && ctrl[emb_pkg::CT_EXT_EN_BIT] && launch &&
                   move_pend;
  assign move_end = (st == emb_pkg::ST_STROBE) && (cnt == 5'h00);

  // straps are caught on the first clock after reset release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      strap_mode <= emb_pkg::MODE_NORMAL;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_mode <= {addr_latch_strobe_in, program_store_strobe_n_in}; // [R3]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !normal) begin
      half <= 1'b0;
      mc_phase <= 2'h0;
      osc_tog <= 1'b0;
    end else begin
      half <= !half; // [R1]
      mc_phase <= mc_phase + 2'h1; // [R8]
      osc_tog <= !osc_tog;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mod_tog <= 1'b0;
    end else if (mod_tick) begin
      mod_tog <= !mod_tog;
    end
  end

  emb_tick_div #(.CW(8)) u_mod_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div(8'(MOD_DIV)),
    .tick(mod_tick)
  );

  emb_tick_div #(.CW(4)) u_tmr_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div(clock_and_stretch_control[emb_pkg::CK_TMR_FAST_BIT] ? emb_pkg::TMR_DIV_FAST :
         emb_pkg::TMR_DIV_STD), // [R10]
    .tick(tmr_tick)
  );

  // pin sequencing: latch strobe train, fetch slots and data moves
  always_ff @(posedge core_clk) begin
    if (!rst_n || !normal) begin
      // pins stay inputs so the straps can be read [R3]
      st <= emb_pkg::ST_IDLE;
      cnt <= 5'h00;
      addr_latch_strobe_out <= 1'b0;
      addr_latch_strobe_oe <= 1'b0;
      program_store_strobe_n_out <= 1'b1;
      program_store_strobe_n_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe <= 8'h00;
      high_addr_port_out <= 8'h00;
      high_addr_port_oe <= 8'h00;
    end else if (!ctrl[emb_pkg::CT_EXT_EN_BIT]) begin
      st <= emb_pkg::ST_IDLE;
      cnt <= 5'h00;
      addr_latch_strobe_out <= half; // [R1]
      addr_latch_strobe_oe <= 1'b1;
      program_store_strobe_n_oe <= 1'b1;
      case (ctrl[emb_pkg::CT_PROGRAM_STORE_STROBE_N_SEL_LSB +: 2]) // [R4]
        emb_pkg::PSEL_LOW: program_store_strobe_n_out <= 1'b0;
        emb_pkg::PSEL_OSC: program_store_strobe_n_out <= osc_tog;
        emb_pkg::PSEL_MOD: program_store_strobe_n_out <= mod_tog;
        default: program_store_strobe_n_out <= 1'b1;
      endcase
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_addr_data_port_out <= gpio_out[7:0]; // [R13]
      low_addr_data_port_oe <= gpio_oe[7:0];
      high_addr_port_out <= gpio_out[15:8];
      high_addr_port_oe <= gpio_oe[15:8];
    end else begin
      addr_latch_strobe_oe <= 1'b1;
      program_store_strobe_n_oe <= 1'b1;
      high_addr_port_oe <= 8'hff; // [R13]
      case (st)
        emb_pkg::ST_ADDR: begin
          // latch strobe stays low through the strobe: one pulse is left out per two strobe clocks
          addr_latch_strobe_out <= 1'b0; // [R2]
          low_addr_data_port_out <= xdata; // [R7]
          low_addr_data_port_oe <= move_dir ? 8'hff : 8'h00;
          read_strobe_n <= move_dir; // [R15]
          write_strobe_n <= !move_dir; // [R15]
          cnt <= strobe_w - 5'h01; // [R12]
          st <= emb_pkg::ST_STROBE;
        end
        emb_pkg::ST_STROBE: begin
          if (cnt == 5'h00) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            cnt <= rest_len - 5'h01; // [R11]
            st <= emb_pkg::ST_RECOVER;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        emb_pkg::ST_FETCH_A: begin
          addr_latch_strobe_out <= 1'b0;
          program_store_strobe_n_out <= 1'b0;
          low_addr_data_port_oe <= 8'h00;
          st <= emb_pkg::ST_FETCH_B;
        end
        default: begin
          // idle, fetch end and move tail keep the strobe train going
          program_store_strobe_n_out <= 1'b1;
          addr_latch_strobe_out <= half; // [R1]
          // write data is held for one clock after the strobe rises
          low_addr_data_port_oe <= 8'h00;
          if (st == emb_pkg::ST_RECOVER && cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
          end
          if (launch) begin
            if (move_pend) begin
              st <= emb_pkg::ST_ADDR;
              low_addr_data_port_out <= data_pointer_reg_act[7:0]; // [R7]
              low_addr_data_port_oe <= 8'hff;
              high_addr_port_out <= data_pointer_reg_act[15:8]; // [R6]
            end else if (fetch_en) begin
              st <= emb_pkg::ST_FETCH_A;
              low_addr_data_port_out <= pc[7:0]; // [R7]
              low_addr_data_port_oe <= 8'hff;
              high_addr_port_out <= pc[15:8]; // [R6]
            end else begin
              st <= emb_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // data move request, completion and captured read byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      move_pend <= 1'b0;
      move_dir <= 1'b0;
      move_done <= 1'b0;
      xdata <= 8'h00;
    end else begin
      if (cmd_ok) begin
        move_pend <= 1'b1;
        move_dir <= avs_writedata[emb_pkg::CMD_WRITE_BIT];
        move_done <= 1'b0;
      end
      if (move_go) begin
        move_pend <= 1'b0;
      end
      if (move_end) begin
        move_done <= 1'b1;
        if (!move_dir) begin
          xdata <= low_addr_data_port_in;
        end
      end else if (wr_ack && idx == emb_pkg::IDX_XDATA && !busy &&
                   avs_byteenable[0]) begin
        xdata <= avs_writedata[7:0];
      end
    end
  end

  // pointers step after a move only when asked, keeping results standard
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dptr0 <= 16'h0000;
      dptr1 <= 16'h0000;
    end else if (move_end && ctrl[emb_pkg::CT_AUTO_INC_BIT]) begin
      if (ctrl[emb_pkg::CT_DATA_POINTER_REG_SEL_BIT]) begin
        dptr1 <= dptr1 + 16'h0001; // [R9]
      end else begin
        dptr0 <= dptr0 + 16'h0001; // [R9]
      end
    end else if (wr_ack && idx == emb_pkg::IDX_DPTR0) begin
      dptr0 <= 16'(be_merge({16'h0000, dptr0}, avs_writedata,
                            avs_byteenable));
    end else if (wr_ack && idx == emb_pkg::IDX_DPTR1) begin
      dptr1 <= 16'(be_merge({16'h0000, dptr1}, avs_writedata,
                            avs_byteenable));
    end
  end

  // fetch counter steps once its address is out, so the next slot sees it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc <= emb_pkg::FETCH_START_ADDR; // [R5]
      fetch_byte <= 8'h00;
    end else begin
      if (wr_ack && idx == emb_pkg::IDX_PC) begin
        pc <= 16'(be_merge({16'h0000, pc}, avs_writedata, avs_byteenable));
      end else if (st == emb_pkg::ST_FETCH_A) begin
        pc <= pc + 16'h0001;
      end
      if (st == emb_pkg::ST_FETCH_B) begin
        fetch_byte <= low_addr_data_port_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timer <= 16'h0000;
    end else if (wr_ack && idx == emb_pkg::IDX_TIMER) begin
      timer <= 16'(be_merge({16'h0000, timer}, avs_writedata,
                            avs_byteenable));
    end else if (tmr_tick) begin
      timer <= timer + 16'h0001; // [R10]
    end
  end

  // configuration registers; stretch code changes only between moves
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clock_and_stretch_control <= emb_pkg::CLOCK_AND_STRETCH_CONTROL_RST; // [R11]
      ctrl <= emb_pkg::CTRL_RST;
      gpio_out <= 16'h0000;
      gpio_oe <= 16'h0000;
    end else if (wr_ack) begin
      if (idx == emb_pkg::IDX_CLOCK_AND_STRETCH_CONTROL && !busy && avs_byteenable[0]) begin
        clock_and_stretch_control <= avs_writedata[3:0];
      end
      if (idx == emb_pkg::IDX_CTRL && !busy && avs_byteenable[0]) begin
        ctrl <= avs_writedata[4:0];
      end
      if (idx == emb_pkg::IDX_GPIO_OUT) begin
        gpio_out <= 16'(be_merge({16'h0000, gpio_out}, avs_writedata,
                                 avs_byteenable));
      end
      if (idx == emb_pkg::IDX_GPIO_OE) begin
        gpio_oe <= 16'(be_merge({16'h0000, gpio_oe}, avs_writedata,
                                avs_byteenable));
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      emb_pkg::IDX_CTRL: rd_mux = {27'h0, ctrl};
      emb_pkg::IDX_DPTR0: rd_mux = {16'h0, dptr0};
      emb_pkg::IDX_DPTR1: rd_mux = {16'h0, dptr1};
      emb_pkg::IDX_XDATA: rd_mux = {24'h0, xdata};
      emb_pkg::IDX_STATUS: rd_mux = {24'h0, normal, fetch_en, mc_phase,
                                     strap_mode, move_done, busy};
      emb_pkg::IDX_PC: rd_mux = {16'h0, pc};
      emb_pkg::IDX_FETCH: rd_mux = {24'h0, fetch_byte};
      emb_pkg::IDX_GPIO_OUT: rd_mux = {16'h0, gpio_out};
      emb_pkg::IDX_GPIO_OE: rd_mux = {16'h0, gpio_oe};
      emb_pkg::IDX_PINS: rd_mux = {16'h0, high_addr_port_in,
                                   low_addr_data_port_in};
      emb_pkg::IDX_TIMER: rd_mux = {16'h0, timer};
      emb_pkg::IDX_CLOCK_AND_STRETCH_CONTROL: rd_mux = {28'h0, clock_and_stretch_control};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // fixed two-cycle answer: waitrequest drops for one cycle per request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule // emb_bus_if

// [emb_bus_if_properties.sv]
/*
  pin-level assertions for emb_bus_if.
  assumes it is bound to every emb_bus_if instance.
*/
module emb_bus_if_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] low_addr_data_port_oe,
  input wire logic [7:0] high_addr_port_out,
  input wire logic [7:0] high_addr_port_oe,
  input wire logic addr_latch_strobe_out,
  input wire logic addr_latch_strobe_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic strb;
  logic [4:0] low_len;
  logic ale;
  assign strb = !read_strobe_n || !write_strobe_n;
  assign ale = addr_latch_strobe_out;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !strb) begin
      low_len <= 5'h00;
    end else begin
      low_len <= low_len + 5'h01;
    end
  end
  property p_ale_short;
    addr_latch_strobe_oe && ale |=> !ale;
  endproperty
  a_ale_short: assert property (p_ale_short) else $error("ale long");
  property p_ale_gap;
    addr_latch_strobe_oe && $past(addr_latch_strobe_oe) && !ale &&
      !$past(ale) |-> strb || $past(strb);
  endproperty
  a_ale_gap: assert property (p_ale_gap) else $error("ale stopped");
  property p_skip;
    strb |-> !ale;
  endproperty
  a_skip: assert property (p_skip) else $error("ale in move");
  property p_excl;
    read_strobe_n || write_strobe_n;
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
  property p_width;
    $rose(!strb) |-> low_len == 5'h02 ||
      (low_len[1:0] == 2'b00 && low_len >= 5'h04 && low_len <= 5'h1c);
  endproperty
  a_width: assert property (p_width) else $error("strobe width");
  property p_hi_hold;
    strb && $past(strb) |-> high_addr_port_oe == 8'hff &&
      $stable(high_addr_port_out);
  endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high addr");
  property p_rd_free;
    !read_strobe_n |-> low_addr_data_port_oe == 8'h00;
  endproperty
  a_rd_free: assert property (p_rd_free) else $error("read oe");
  property p_wr_drive;
    !write_strobe_n |-> low_addr_data_port_oe == 8'hff;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write oe");
  c_rd: cover property ($fell(read_strobe_n));
  c_wr: cover property ($fell(write_strobe_n));
  c_end: cover property (strb ##1 !strb);
endmodule // emb_bus_if_properties
bind emb_bus_if emb_bus_if_properties i_emb_bus_if_properties (
  .core_clk, .rst_n, .low_addr_data_port_oe, .high_addr_port_out,
  .high_addr_port_oe, .addr_latch_strobe_out, .addr_latch_strobe_oe,
  .read_strobe_n, .write_strobe_n);

// [emb_bus_if_tb.sv]
/*
  self-checking bench for emb_bus_if with an external memory model.
  assumes a 25 MHz core clock and MOD_DIV of 2 to keep runs short.
*/
module emb_bus_if_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [31:0] seed = 32'h48afcb7c;
  logic avs_waitrequest, ale_out, ale_oe, ale_in, ps_out, ps_oe, ps_in;
  logic [7:0] lo_out, lo_oe, lo_in, hi_out, hi_oe, hi_in, hi_drv = 8'h00;
  logic rd_n, wr_n, strap_ale = 1'b1, strap_ps = 1'b1, fetch_n = 1'b1;
  logic [1:0] strap_mode;
  logic [15:0] first_fetch;
  int lag = 0, width, nfetch, n_mismatch = 0, n_checks = 0, cycles = 0;
  logic [7:0] ref_mem [int];
  assign hi_in = (hi_oe & hi_out) | (~hi_oe & hi_drv);
  assign ale_in = ale_oe ? ale_out : strap_ale;
  assign ps_in = ps_oe ? ps_out : strap_ps;
  emb_bus_if #(.MOD_DIV(2)) i_emb_bus_if (.core_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .low_addr_data_port_in(lo_in),
    .low_addr_data_port_out(lo_out), .low_addr_data_port_oe(lo_oe),
    .high_addr_port_in(hi_in), .high_addr_port_out(hi_out),
    .high_addr_port_oe(hi_oe), .addr_latch_strobe_in(ale_in),
    .addr_latch_strobe_out(ale_out), .addr_latch_strobe_oe(ale_oe),
    .program_store_strobe_n_in(ps_in), .program_store_strobe_n_out(ps_out),
    .program_store_strobe_n_oe(ps_oe), .external_fetch_select_n(fetch_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .strap_mode);
  emb_mem_model i_emb_mem_model (.core_clk, .ale(ale_in), .program_store_strobe_n_n(ps_in),
    .rd_n, .wr_n, .hi_addr(hi_in), .lo_out, .lo_oe, .lag, .lo_pin(lo_in),
    .width, .nfetch, .first_fetch);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held from one edge until waitrequest is seen low
  task automatic av(input logic wr, input logic [7:0] idx,
                    input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_done;
    do av(1'b0, emb_pkg::IDX_STATUS, 32'h0); while (rd[1] !== 1'b1);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    logic [15:0] a;
    logic [7:0] dp;
    logic p;
    int w, t;
    do_reset();
    av(1'b0, emb_pkg::IDX_CLOCK_AND_STRETCH_CONTROL, 32'h0);
    chk(rd, 32'h1);
    av(1'b0, emb_pkg::IDX_PC, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, 8'h40, 32'hffffffff);
    av(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, strap_mode}, {30'h0, emb_pkg::MODE_NORMAL});
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 2 : 4 * k;
      seed = lfsr(seed);
      a = {2'b10, seed[13:0]};
      dp = k[0] ? emb_pkg::IDX_DPTR1 : emb_pkg::IDX_DPTR0;
      av(1'b1, emb_pkg::IDX_CLOCK_AND_STRETCH_CONTROL, k);
      av(1'b1, emb_pkg::IDX_CTRL, k[0] ? 32'h19 : 32'h11);
      av(1'b1, dp, a);
      av(1'b1, emb_pkg::IDX_XDATA, seed[23:16]);
      av(1'b1, emb_pkg::IDX_CMD, 32'h2);
      wait_done();
      ref_mem[a] = seed[23:16];
      chk(width, w);
      chk(i_emb_mem_model.mem[a], ref_mem[a]);
      av(1'b0, dp, 32'h0);
      chk(rd, a + 32'h1);
      av(1'b1, dp, a);
      lag = w - 1;
      av(1'b1, emb_pkg::IDX_CMD, 32'h1);
      wait_done();
      lag = 0;
      av(1'b0, emb_pkg::IDX_XDATA, 32'h0);
      chk(rd, ref_mem[a]);
      chk(width, w);
    end
    $display("test moves done");
    fetch_n <= 1'b0;
    repeat (40) @(posedge core_clk);
    fetch_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    av(1'b0, emb_pkg::IDX_PC, 32'h0);
    a = rd[15:0];
    av(1'b0, emb_pkg::IDX_FETCH, 32'h0);
    chk({16'h0, first_fetch}, 32'h0);
    chk(nfetch, a);
    a = a - 16'h1;
    chk(rd, 8'h5a ^ a[7:0] ^ a[15:8]);
    $display("test fetch done");
    for (int s = 0; s < 4; s++) begin
      av(1'b1, emb_pkg::IDX_CTRL, s << 1);
      repeat (4) @(posedge core_clk);
      p = ps_out;
      t = 0;
      repeat (16) begin
        @(posedge core_clk);
        if (ps_out !== p) t++;
        p = ps_out;
      end
      if (s < 2) begin
        chk({p, t[7:0]}, {s == 0, 8'h00});
      end else begin
        chk(t, s == 2 ? 16 : 8);
      end
    end
    $display("test program store done");
    seed = lfsr(seed);
    hi_drv <= seed[31:24];
    av(1'b1, emb_pkg::IDX_GPIO_OE, 32'hffff);
    av(1'b1, emb_pkg::IDX_GPIO_OUT, seed[15:0]);
    repeat (2) @(posedge core_clk);
    chk({hi_oe, lo_oe, hi_out, lo_out}, {16'hffff, seed[15:0]});
    av(1'b1, emb_pkg::IDX_GPIO_OE, 32'h0);
    av(1'b0, emb_pkg::IDX_PINS, 32'h0);
    chk(rd[15:8], seed[31:24]);
    $display("test gpio done");
    for (int f = 0; f < 2; f++) begin
      av(1'b1, emb_pkg::IDX_CLOCK_AND_STRETCH_CONTROL, f << emb_pkg::CK_TMR_FAST_BIT);
      repeat (12) @(posedge core_clk);
      av(1'b0, emb_pkg::IDX_STATUS, 32'h0);
      a = rd[15:0];
      av(1'b0, emb_pkg::IDX_STATUS, 32'h0);
      chk(2'(rd[5:4] - a[5:4]), 2'h3);
      av(1'b0, emb_pkg::IDX_TIMER, 32'h0);
      w = rd;
      repeat (45) @(posedge core_clk);
      av(1'b0, emb_pkg::IDX_TIMER, 32'h0);
      chk(rd - w, f ? 32'h0000_000c : 32'h0000_0004);
    end
    $display("test timer done");
    strap_ale <= 1'b0;
    do_reset();
    repeat (4) @(posedge core_clk);
    chk({strap_mode, ale_oe, ps_oe, hi_oe, lo_oe},
        {emb_pkg::MODE_PARALLEL, 18'h0});
    $display("test straps done");
    give_verdict();
  end
endmodule // emb_bus_if_tb

// [emb_mem_model.sv]
/*
  external memory with its address latch, far side of emb_bus_if.
  assumes the bench resolves the strobe pins and feeds their levels here.
*/
module emb_mem_model (
  input wire logic core_clk,
  input wire logic ale,
  input wire logic program_store_strobe_n_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] hi_addr,
  input wire logic [7:0] lo_out,
  input wire logic [7:0] lo_oe,
  input wire logic [31:0] lag,
  output logic [7:0] lo_pin,
  output int width,
  output int nfetch,
  output logic [15:0] first_fetch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo;
  logic [7:0] last;
  logic drive;
  int scnt;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h5a ^ i[7:0] ^ i[15:8];
    end
    nfetch = 0;
    width = 0;
    scnt = 0;
    last = 8'h00;
    first_fetch = 16'hffff;
  end
  // a slow part answers only after lag strobe clocks
  assign drive = !program_store_strobe_n_n || (!rd_n && scnt >= lag);
  // a released line shows the inverse of its last level, never a stale copy
  assign lo_pin = (lo_oe & lo_out) |
    (~lo_oe & (drive ? mem[{hi_addr, lat_lo}] : ~last));
  always @(posedge core_clk) begin
    last <= lo_pin;
    if (ale) lat_lo <= lo_pin;
    if (!wr_n) mem[{hi_addr, lat_lo}] <= lo_pin;
    if (!program_store_strobe_n_n) begin
      nfetch <= nfetch + 1;
      if (nfetch == 0) first_fetch <= {hi_addr, lat_lo};
    end
    if (rd_n && wr_n) begin
      if (scnt != 0) width <= scnt;
      scnt <= 0;
    end else begin
      scnt <= scnt + 1;
    end
  end
endmodule // emb_mem_model

// [emb_pkg.sv]
/*
  constants, register map and state encoding for the external memory bus
  interface. assumes a single 25 MHz core clock and a 32-bit avalon slave
  whose byte address is four times the register index.
*/
package emb_pkg;

  // register indices; byte address = index * 4
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_DPTR0 = 8'h01;
  localparam logic [7:0] IDX_DPTR1 = 8'h02;
  localparam logic [7:0] IDX_XDATA = 8'h03;
  localparam logic [7:0] IDX_CMD = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_PC = 8'h06;
  localparam logic [7:0] IDX_FETCH = 8'h07;
  localparam logic [7:0] IDX_GPIO_OUT = 8'h08;
  localparam logic [7:0] IDX_GPIO_OE = 8'h09;
  localparam logic [7:0] IDX_PINS = 8'h0a;
  localparam logic [7:0] IDX_TIMER = 8'h0b;
  localparam logic [7:0] IDX_CLOCK_AND_STRETCH_CONTROL = 8'h8e;

  // clock_and_stretch_control fields
  localparam int CK_STRETCH_LSB = 0;
  localparam int CK_TMR_FAST_BIT = 3;
  localparam logic [3:0] CLOCK_AND_STRETCH_CONTROL_RST = 4'h1;

  // control register fields
  localparam int CT_EXT_EN_BIT = 0;
  localparam int CT_PROGRAM_STORE_STROBE_N_SEL_LSB = 1;
  localparam int CT_DATA_POINTER_REG_SEL_BIT = 3;
  localparam int CT_AUTO_INC_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // command register bits
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;

  // program-store pin use while the external bus is off
  localparam logic [1:0] PSEL_HIGH = 2'h0;
  localparam logic [1:0] PSEL_LOW = 2'h1;
  localparam logic [1:0] PSEL_OSC = 2'h2;
  localparam logic [1:0] PSEL_MOD = 2'h3;

  // strap modes, {latch strobe pin, program-store pin}
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] MODE_PARALLEL = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;

  localparam logic [15:0] FETCH_START_ADDR = 16'h0000;

  // timing in core clocks
  localparam int CLK_PER_INSTR = 4;
  localparam logic [3:0] TMR_DIV_STD = 4'hc;
  localparam logic [3:0] TMR_DIV_FAST = 4'h4;
  localparam logic [4:0] STROBE_MIN = 5'h02;
  localparam logic [4:0] REST_SHORT = 5'h05;
  localparam logic [4:0] REST_LONG = 5'h07;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STROBE = 3'b011,
    ST_RECOVER = 3'b010,
    ST_FETCH_A = 3'b110,
    ST_FETCH_B = 3'b111
  } emb_state_e;

endpackage

// [emb_tick_div.sv]
/*
  programmable divider giving a one-cycle enable pulse every div clocks.
  assumes div is at least one; a change of div applies at once to the count under way.
*/
module emb_tick_div #(
  parameter int CW = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [CW-1:0] div,
  output logic tick
);

  logic [CW-1:0] cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= div - 1'b1) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // emb_tick_div
